//--- sio_sram_consts.vh
`ifndef SIO_SRAM_CONSTS_VH
`define SIO_SRAM_CONSTS_VH

// x18 organization: word address, data width, byte lanes
`define ADDR_W        22
`define DATA_W        18
`define BYTE_W        9
`define BE_W          2
// Write FIFO entry: {address, byte enables, data}
`define WF_W          42
`define WF_DEPTH      32
`define WF_AW         5
// Loop lock time in input clock periods
`define LOCK_CYCLES   11'h0400
`define LOCK_CNT_W    11
`define BURST_NEXT    22'h00_0001

`endif

//--- sync_fifo.v
`timescale 1ns/1ns
module sync_fifo #(
	parameter WIDTH = 42,
	parameter DEPTH = 32,
	parameter AW    = 5
) (
	input  wire             i_ref_clk,
	input  wire             i_rst,
	input  wire             i_in_valid,
	output wire             o_in_ready,
	input  wire [WIDTH-1:0] i_in_data,
	output wire             o_out_valid,
	input  wire             i_out_ready,
	output wire [WIDTH-1:0] o_out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0]      wr_ptr_r;
	reg [AW:0]      rd_ptr_r;
	wire            full;
	wire            empty;

	assign empty       = (wr_ptr_r == rd_ptr_r);
	assign full        = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
	                     (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
	assign o_in_ready  = ~full;
	assign o_out_valid = ~empty;
	assign o_out_data  = mem[rd_ptr_r[AW-1:0]];

	always @(posedge i_ref_clk) begin
		if (i_in_valid && !full)
			mem[wr_ptr_r[AW-1:0]] <= i_in_data;
	end

	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			wr_ptr_r <= {(AW+1){1'b0}};
			rd_ptr_r <= {(AW+1){1'b0}};
		end else begin
			if (i_in_valid && !full)
				wr_ptr_r <= wr_ptr_r + 1'b1;
			if (i_out_ready && !empty)
				rd_ptr_r <= rd_ptr_r + 1'b1;
		end
	end
endmodule

//--- sio_sram_port.v
// Behaviour
// RQ1 - Address captured on input clock rise
// RQ2 - Address ignored while deselected
// RQ3 - Low address bits pick burst start word
// RQ4 - Cycle request latches address and direction
// RQ5 - Direction high reads, low writes
// RQ6 - Byte enables gate each write word
// RQ7 - Control on true rise, data both rises
// RQ8 - Read words on comp, then true rise
// RQ9 - Tied-high output clocks select input pair
// RQ10 - Bypass input low skips loop lock
// RQ11 - Clock pairs ideally half period apart
// RQ12 - Write words on next true, comp rise
// RQ13 - Read words at t+1 comp, t+2 true
// RQ14 - Echo clocks run continuously
// RQ15 - Read bus released when idle
`timescale 1ns/1ns
`include "sio_sram_consts.vh"
module sio_sram_port (
	input  wire               i_ref_clk,
	input  wire               i_rst,
	input  wire               i_in_clk,
	input  wire               i_in_clk_n,
	input  wire               i_out_clk,
	input  wire               i_out_clk_n,
	input  wire [`ADDR_W-1:0] i_addr_in,
	input  wire               i_cycle_request_n,
	input  wire               i_rd_wr_n,
	input  wire [`DATA_W-1:0] i_wdata,
	input  wire [`BE_W-1:0]   i_byte_write_enable_n,
	input  wire               i_loop_bypass_n,
	output reg  [`DATA_W-1:0] o_rdata,
	output reg                o_rdata_oe_n,
	output reg                o_echo_clk_true,
	output reg                o_echo_clk_comp,
	output reg                o_loop_ready,
	output reg                o_wfifo_ready
);
	function rose;
		input cur;
		input prev;
		begin
			rose = cur & ~prev;
		end
	endfunction

	reg [`BYTE_W-1:0] mem_lo [0:(1<<`ADDR_W)-1];
	reg [`BYTE_W-1:0] mem_hi [0:(1<<`ADDR_W)-1];

	// Previous clock levels for rise detection on the sampling clock
	reg                   k_prev_r;
	reg                   kn_prev_r;
	reg                   c_prev_r;
	reg                   cn_prev_r;
	reg                   wr_pend_r;
	reg                   wr_second_r;
	reg [`ADDR_W-1:0]     wr_addr_r;
	reg                   fetch_r;
	reg                   fv_r;
	reg                   av_r;
	reg                   h1v_r;
	reg [`ADDR_W-1:0]     rd_addr_r;
	// Fetched pair, armed pair and held second word of a read
	reg [`DATA_W-1:0]     f0_r;
	reg [`DATA_W-1:0]     f1_r;
	reg [`DATA_W-1:0]     a0_r;
	reg [`DATA_W-1:0]     a1_r;
	reg [`DATA_W-1:0]     h1_r;
	reg [`LOCK_CNT_W-1:0] lock_cnt_r;
	reg                   push_r;
	reg [`WF_W-1:0]       push_data_r;

	wire                  k_rise;
	wire                  kn_rise;
	wire                  ref_t;
	wire                  ref_c;
	wire                  ref_t_rise;
	wire                  ref_c_rise;
	wire                  use_k;
	wire              pop_valid, push_ready, pop_ready;
	wire [`WF_W-1:0]  pop_data;
	wire [`ADDR_W-1:0] pop_addr;
	wire [`BE_W-1:0]  pop_be_n;

	assign k_rise  = rose(i_in_clk, k_prev_r);
	assign kn_rise = rose(i_in_clk_n, kn_prev_r);
	// Output clocks held high hand timing back to the input pair
	assign use_k   = i_out_clk & i_out_clk_n; // [RQ9]
	assign ref_t   = use_k ? i_in_clk : i_out_clk;
	assign ref_c   = use_k ? i_in_clk_n : i_out_clk_n;
	assign ref_t_rise = rose(ref_t, use_k ? k_prev_r : c_prev_r);
	assign ref_c_rise = rose(ref_c, use_k ? kn_prev_r : cn_prev_r);

	// Memory port goes to the read fetch first; writes wait in the FIFO
	assign pop_ready = ~fetch_r;
	assign pop_addr  = pop_data[`WF_W-1:`WF_W-`ADDR_W];
	assign pop_be_n  = pop_data[`DATA_W+`BE_W-1:`DATA_W];

	sync_fifo #(
		.WIDTH(`WF_W),
		.DEPTH(`WF_DEPTH),
		.AW   (`WF_AW)
	) u_wfifo (
		.i_ref_clk  (i_ref_clk),
		.i_rst      (i_rst),
		.i_in_valid (push_r),
		.o_in_ready (push_ready),
		.i_in_data  (push_data_r),
		.o_out_valid(pop_valid),
		.i_out_ready(pop_ready),
		.o_out_data (pop_data)
	);

	always @(posedge i_ref_clk) begin
		if (pop_valid && pop_ready) begin
			if (!pop_be_n[0]) // [RQ6]
				mem_lo[pop_addr] <= pop_data[`BYTE_W-1:0];
			if (!pop_be_n[1]) // [RQ6]
				mem_hi[pop_addr] <= pop_data[`DATA_W-1:`BYTE_W];
		end
		if (fetch_r) begin
			f0_r <= {mem_hi[rd_addr_r], mem_lo[rd_addr_r]}; // [RQ3]
			f1_r <= {mem_hi[rd_addr_r + `BURST_NEXT],
			         mem_lo[rd_addr_r + `BURST_NEXT]};
		end
	end

	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			k_prev_r        <= 1'b0;
			kn_prev_r       <= 1'b0;
			c_prev_r        <= 1'b0;
			cn_prev_r       <= 1'b0;
			wr_pend_r       <= 1'b0;
			wr_second_r     <= 1'b0;
			wr_addr_r       <= {`ADDR_W{1'b0}};
			fetch_r         <= 1'b0;
			rd_addr_r       <= {`ADDR_W{1'b0}};
			fv_r            <= 1'b0;
			av_r            <= 1'b0;
			h1v_r           <= 1'b0;
			a0_r            <= {`DATA_W{1'b0}};
			a1_r            <= {`DATA_W{1'b0}};
			h1_r            <= {`DATA_W{1'b0}};
			push_r          <= 1'b0;
			push_data_r     <= {`WF_W{1'b0}};
			lock_cnt_r      <= {`LOCK_CNT_W{1'b0}};
			o_rdata         <= {`DATA_W{1'b0}};
			o_rdata_oe_n    <= 1'b1;
			o_echo_clk_true <= 1'b0;
			o_echo_clk_comp <= 1'b0;
			o_loop_ready    <= 1'b0;
			o_wfifo_ready   <= 1'b1;
		end else begin
			k_prev_r      <= i_in_clk;
			kn_prev_r     <= i_in_clk_n;
			c_prev_r      <= i_out_clk;
			cn_prev_r     <= i_out_clk_n;
			o_wfifo_ready <= push_ready;
			// Echo clocks follow the output reference even when idle
			o_echo_clk_true <= ref_t; // [RQ14]
			o_echo_clk_comp <= ref_c; // [RQ14]
			// Bypassed loop needs no settle time
			if (!i_loop_bypass_n) begin // [RQ10]
				o_loop_ready <= 1'b1;
				lock_cnt_r   <= {`LOCK_CNT_W{1'b0}};
			end else if (k_rise && lock_cnt_r != `LOCK_CYCLES) begin
				lock_cnt_r   <= lock_cnt_r + 1'b1;
				o_loop_ready <= 1'b0;
			end else if (lock_cnt_r == `LOCK_CYCLES) begin
				o_loop_ready <= 1'b1;
			end

			push_r  <= 1'b0;
			fetch_r <= 1'b0;
			if (fetch_r)
				fv_r <= 1'b1;
			// Overflow drops words; the controller sees o_wfifo_ready
			if (kn_rise && wr_second_r) begin // [RQ7] [RQ12]
				push_r      <= 1'b1;
				push_data_r <= {wr_addr_r, i_byte_write_enable_n, i_wdata};
				wr_second_r <= 1'b0;
			end
			if (k_rise) begin
				wr_second_r <= wr_pend_r;
				if (wr_pend_r) begin // [RQ12]
					push_r      <= 1'b1;
					push_data_r <= {wr_addr_r, i_byte_write_enable_n,
					                i_wdata}; // [RQ6]
					wr_addr_r   <= wr_addr_r + `BURST_NEXT;
				end
				av_r <= fv_r; // [RQ13]
				a0_r <= f0_r;
				a1_r <= f1_r;
				fv_r <= 1'b0;
				wr_pend_r <= 1'b0;
				if (!i_cycle_request_n) begin // [RQ1] [RQ2] [RQ4]
					if (i_rd_wr_n) begin // [RQ5]
						fetch_r   <= 1'b1;
						rd_addr_r <= i_addr_in; // [RQ3]
					end else begin
						wr_pend_r <= 1'b1;
						wr_addr_r <= i_addr_in; // [RQ3]
					end
				end
			end
			if (ref_c_rise) begin
				if (av_r && !(k_rise && fv_r)) begin // [RQ8] [RQ13]
					o_rdata      <= a0_r;
					o_rdata_oe_n <= 1'b0;
					h1_r         <= a1_r;
					h1v_r        <= 1'b1;
					if (!k_rise)
						av_r <= 1'b0;
				end else begin
					o_rdata_oe_n <= 1'b1; // [RQ15]
				end
			end else if (ref_t_rise && h1v_r) begin // [RQ8] [RQ13]
				o_rdata <= h1_r;
				h1v_r   <= 1'b0;
			end
		end
	end
endmodule

//--- mem_ctrl_model.sv
`timescale 1ns/1ns
module mem_ctrl_model (
	input  wire	i_ref_clk,
	output wire	o_in_clk,
	output wire	o_in_clk_n,
	output wire	o_out_clk,
	output wire	o_out_clk_n
);
	reg [2:0]	phase_r = 3'h0;
	always @(posedge i_ref_clk) begin
		phase_r <= phase_r + 3'h1;
	end
	// Eight-cycle pair, halves of four so edge detect never misses
	assign o_in_clk = phase_r[2];
	assign o_in_clk_n = ~phase_r[2];
	// Output pair tied high for good, never toggled
	assign o_out_clk = 1'h1;
	assign o_out_clk_n = 1'h1;
endmodule

//--- sio_sram_port_props.sv
`timescale 1ns/1ns
`include "sio_sram_consts.vh"
module sio_sram_props (
	input wire			i_ref_clk,
	input wire			i_rst,
	input wire			i_in_clk,
	input wire			i_in_clk_n,
	input wire			i_cycle_request_n,
	input wire			i_rd_wr_n,
	input wire			i_loop_bypass_n,
	input wire [`DATA_W-1:0]	o_rdata,
	input wire			o_rdata_oe_n,
	input wire			o_echo_clk_true,
	input wire			o_echo_clk_comp,
	input wire			o_loop_ready,
	input wire			o_wfifo_ready
);
	reg [4:0]	age_r;
	reg		k_r;
	always @(posedge i_ref_clk) begin
		k_r <= i_in_clk;
		if (i_rst || (i_in_clk && !k_r && !i_cycle_request_n && i_rd_wr_n))
			age_r <= 5'h00;
		else if (age_r != 5'h1f)
			age_r <= age_r + 5'h01;
	end
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	sequence comp_rise;
		$past(i_in_clk_n) && !$past(i_in_clk_n, 2);
	endsequence
	sequence true_rise;
		$past(i_in_clk) && !$past(i_in_clk, 2);
	endsequence
	echo_true_a: assert property (
		!$past(i_rst) |-> o_echo_clk_true == $past(i_in_clk))
		else $error("echo true lost step");
	echo_comp_a: assert property (
		!$past(i_rst) |-> o_echo_clk_comp == $past(i_in_clk_n))
		else $error("echo comp lost step");
	oe_edge_a: assert property (
		$changed(o_rdata_oe_n) && !$past(i_rst) |-> comp_rise)
		else $error("read enable off comp rise");
	rdata_edge_a: assert property (
		$changed(o_rdata) && !$past(i_rst) |-> true_rise or comp_rise)
		else $error("read data off reference rise");
	bypass_a: assert property (
		!i_loop_bypass_n |=> o_loop_ready) else $error("bypass not ready");
	reset_vals_a: assert property (
		$past(i_rst) |-> o_rdata_oe_n && o_wfifo_ready && !o_loop_ready)
		else $error("bad reset outputs");
	burst_hold_a: assert property (
		$fell(o_rdata_oe_n) |-> !o_rdata_oe_n [*8])
		else $error("burst cut short");
	// Bound assumes an eight-cycle input clock
	idle_float_a: assert property (
		!o_rdata_oe_n |-> age_r < 5'h18) else $error("drive without read");
endmodule
bind sio_sram_port sio_sram_props u_props (.i_ref_clk, .i_rst, .i_in_clk,
	.i_in_clk_n, .i_cycle_request_n, .i_rd_wr_n, .i_loop_bypass_n, .o_rdata,
	.o_rdata_oe_n, .o_echo_clk_true, .o_echo_clk_comp, .o_loop_ready,
	.o_wfifo_ready);

//--- tb.sv
`timescale 1ns/1ns
`include "sio_sram_consts.vh"
module tb;
	reg			clk = 1'h0;
	reg			rst = 1'h1;
	reg [`ADDR_W-1:0]	addr = 22'h00_0000;
	reg			req_n = 1'h1;
	reg			rw = 1'h1;
	reg [`DATA_W-1:0]	wd = 18'h0_0000;
	reg [`BE_W-1:0]		be_n = 2'h3;
	wire [`DATA_W-1:0]	rd;
	wire			k, kn, c, cn, oe_n, lr, fr;
	integer			fails = 0;
	integer			samples_checked = 0;
	always #5 clk = ~clk;
	mem_ctrl_model u_ctl (.i_ref_clk(clk), .o_in_clk(k), .o_in_clk_n(kn),
		.o_out_clk(c), .o_out_clk_n(cn));
	sio_sram_port u_dut (.i_ref_clk(clk), .i_rst(rst), .i_in_clk(k),
		.i_in_clk_n(kn), .i_out_clk(c), .i_out_clk_n(cn), .i_addr_in(addr),
		.i_cycle_request_n(req_n), .i_rd_wr_n(rw), .i_wdata(wd),
		.i_byte_write_enable_n(be_n), .i_loop_bypass_n(1'h0), .o_rdata(rd),
		.o_rdata_oe_n(oe_n), .o_echo_clk_true(), .o_echo_clk_comp(),
		.o_loop_ready(lr), .o_wfifo_ready(fr));
	task close_out; begin
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	end endtask
	task check(input string n, input [`DATA_W-1:0] s, e); begin
		samples_checked = samples_checked + 1;
		if (s !== e) begin
			fails = fails + 1;
			$display("[FAIL] %s exp %h seen %h", n, e, s);
		end
	end endtask
	// Waits for a rise of the input clock (s=0) or its complement
	task w(input s);
		integer i;
		begin
			for (i = 0; i < 40 && (s ? kn : k) !== 1'h0; i = i + 1)
				@(negedge clk);
			for (i = i; i < 40 && (s ? kn : k) !== 1'h1; i = i + 1)
				@(negedge clk);
			if (i >= 40) begin
				fails = fails + 1;
				close_out;
			end
		end
	endtask
	task idle; begin
		w(0);
		req_n = 1'h1;
		rw = 1'h1;
		addr = 22'h3f_ffff;
		w(1);
		repeat (3) @(negedge clk);
		check("oe", oe_n, 1'h1);
		check("lock", lr, 1'h1);
		check("room", fr, 1'h1);
	end endtask
	task wr_op(input [`ADDR_W-1:0] a, input [`DATA_W-1:0] d0, d1,
		input [`BE_W-1:0] b0, b1); begin
		w(0);
		req_n = 1'h0;
		rw = 1'h0;
		addr = a;
		w(0);
		req_n = 1'h1;
		wd = d0;
		be_n = b0;
		w(1);
		wd = d1;
		be_n = b1;
	end endtask
	task rd_op(input [`ADDR_W-1:0] a, input [`DATA_W-1:0] e0, e1); begin
		w(0);
		req_n = 1'h0;
		rw = 1'h1;
		addr = a;
		w(0);
		req_n = 1'h1;
		w(1);
		repeat (3) @(negedge clk);
		check("oe", oe_n, 1'h0);
		check("q0", rd, e0);
		w(0);
		repeat (3) @(negedge clk);
		check("q1", rd, e1);
	end endtask
	initial begin
		repeat (3) @(negedge clk);
		rst = 1'h0;
		check("oe", oe_n, 1'h1);
		idle;
		wr_op(22'h00_0013, 18'h1_2345, 18'h2_3456, 2'h0, 2'h0);
		wr_op(22'h00_0013, 18'h0_0abc, 18'h3_ffff, 2'h2, 2'h3);
		idle;
		rd_op(22'h00_0013, {9'h091, 9'h0bc}, 18'h2_3456);
		idle;
		close_out;
	end
endmodule
